// >>> hw/paev_pkg.sv
package paev_pkg;

  localparam int unsigned NUM_ANALOGUE = 8;
  localparam int unsigned NUM_DIGITAL = 4;
  localparam int unsigned NUM_ALARMS = NUM_ANALOGUE + NUM_DIGITAL;
  localparam int unsigned NUM_RELAYS = 4;
  localparam int unsigned VALUE_W = 16;

  // Register byte offsets.
  localparam logic [11:0] OFS_ACK = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_UNACK = 12'h008;
  localparam logic [11:0] OFS_INHIBIT = 12'h00c;
  localparam logic [11:0] OFS_DIG_BASE = 12'h010;
  localparam logic [11:0] OFS_RELAY_BASE = 12'h020;
  localparam logic [11:0] OFS_ANA_BASE = 12'h040;
  localparam logic [11:0] OFS_ANA_STRIDE = 12'h010;
  localparam logic [11:0] OFS_ANA_CFG = 12'h000;
  localparam logic [11:0] OFS_ANA_REF = 12'h004;
  localparam logic [11:0] OFS_ANA_THR = 12'h008;
  localparam logic [11:0] OFS_ANA_HYST = 12'h00c;

  // Field positions.
  localparam int unsigned FLD_TYPE_LSB = 0;
  localparam int unsigned FLD_LATCH_LSB = 4;
  localparam int unsigned FLD_BLOCK = 8;
  localparam int unsigned FLD_SRC_LSB = 12;
  localparam int unsigned FLD_RELAY_INV = 16;

  // Flash divider: 0.5 s per half period at 100 MHz.
  localparam int unsigned FLASH_HALF_MS = 500;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * 1000 * CLK_MHZ;

  typedef enum logic [2:0] {
    unconfigured_type, absolute_high_type, absolute_low_type,
    deviation_high_type, deviation_low_type, deviation_band_type
  } paev_ana_kind_type;

  typedef enum logic [2:0] {
    rising_type, falling_type, either_edge_type, high_level_type, low_level_type
  } paev_dig_kind_type;

  typedef enum logic [1:0] {
    latch_none_type, latch_auto_type, latch_manual_type, latch_event_type
  } paev_latch_type;

  typedef struct packed {
    paev_latch_type latch;
    logic block;
  } paev_mode_type;

  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic RST_RELAY_INV = 1'b1;

endpackage

// >>> hw/paev_latch_unit.sv
`timescale 1ns/1ps
module paev_latch_unit
  import paev_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cond,
  input wire logic edge_event,
  input wire logic inhibit,
  input wire logic ack,
  input wire logic rearm,
  input wire paev_pkg::paev_mode_type mode,
  output logic active,
  output logic unacked
);
  logic active_q;
  logic acked_q;
  logic blocked_q;
  logic raise;

  // An edge alarm raises on its event; a level alarm raises on its level.
  assign raise = (cond | edge_event) & ~blocked_q & ~inhibit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blocked_q <= 1'b1;
    end else if (rearm && mode.block) begin
      blocked_q <= 1'b1; // R23
    end else if (!cond || !mode.block) begin
      blocked_q <= 1'b0; // R23
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q <= 1'b0;
      acked_q <= 1'b0;
    end else if (inhibit) begin
      active_q <= 1'b0; // R22
      acked_q <= 1'b0;
    end else if (raise && !active_q) begin
      active_q <= 1'b1;
      acked_q <= 1'b0;
    end else if (active_q) begin
      case (mode.latch)
        latch_auto_type: begin
          if (ack) begin
            acked_q <= 1'b1; // R13
          end
          if (!cond && (acked_q || ack)) begin
            active_q <= 1'b0; // R12
            acked_q <= 1'b0;
          end
        end
        latch_manual_type: begin
          if (ack && !cond) begin
            active_q <= 1'b0; // R14
            acked_q <= 1'b0;
          end
        end
        default: begin
          if (ack) begin
            acked_q <= 1'b1; // R10
          end
          if (!cond) begin
            active_q <= 1'b0; // R8 R9
            acked_q <= 1'b0;
          end
        end
      endcase
    end
  end

  assign active = active_q; // R21
  assign unacked = active_q & ~acked_q & (mode.latch != latch_event_type);

endmodule

// >>> hw/paev_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// (R1) Rising-trigger digital alarm raises on input going low to high.
// (R2) Falling-trigger digital alarm raises on input going high to low.
// (R3) Either-edge digital alarm raises on any input change.
// (R4) Level types: condition present while input high, or while low.
// (R5) Each relay follows OR of up to twelve selected alarms.
// (R6) Indicator flashes while any active alarm not event-latched is unacknowledged.
// (R7) Indicator steady on once all active alarms are acknowledged.
// (R8) Non-latched alarm holds relay in alarm while condition persists.
// (R9) Non-latched alarm clearing unacknowledged cancels indication and relay.
// (R10) Non-latched acknowledged alarm goes steady, clears with the condition.
// (R11) Relay polarity selectable; default de-energised in alarm.
// (R12) Latched alarms stay active until condition gone and acknowledged; event-latched alarms here clear with the condition without acknowledge.
// (R13) Auto-latched alarms remember acknowledge given during the condition.
// (R14) Manual-latched alarms ignore acknowledge until the condition is safe.
// (R15) Eight independent analogue alarm instances.
// (R16) Six analogue types; unconfigured disables the alarm.
// (R17) Analogue alarm compares selected input against threshold.
// (R18) Deviation types measure threshold relative to reference.
// (R19) High, low and band trigger as their names say.
// (R20) Active analogue alarm clears only beyond hysteresis into safe region.
// (R21) Each alarm exposes a read-only on/off output state.
// (R22) Inhibit holds alarm output inactive.
// (R23) Blocking suppresses activation until first safe; re-arms on setpoint change.
// (R24) Acknowledge is a single-cycle pulse applying to indicated alarms.
module paev_top
  import paev_pkg::*;
#(
  parameter int unsigned FLASH_HALF = FLASH_HALF_CYC,
  parameter int unsigned NUM_INPUTS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_INPUTS*paev_pkg::VALUE_W-1:0] analogue_in,
  input wire logic [paev_pkg::NUM_DIGITAL-1:0] digital_in,
  input wire logic [paev_pkg::NUM_ALARMS-1:0] inhibit_in,
  input wire logic ack_in,
  output logic alarm_indicator,
  output logic [paev_pkg::NUM_RELAYS-1:0] relay_out
);
  import paev_pkg::*;

  // The source select is four bits wide and the flash divider needs a period.
  // Values outside that range are refused at elaboration.
  if (NUM_INPUTS < 1 || NUM_INPUTS > 16 || FLASH_HALF < 1) begin : g_param_check
    $error("paev_top: unsupported parameter value");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  logic [NUM_DIGITAL-1:0] dig_s1_q, dig_s2_q, dig_prev_q;
  logic [NUM_ALARMS-1:0] inh_s1_q, inh_s2_q;
  logic ack_s1_q, ack_s2_q, ack_prev_q;
  logic ack_pulse;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dig_s1_q <= '0;
      dig_s2_q <= '0;
      dig_prev_q <= '0;
      inh_s1_q <= '0;
      inh_s2_q <= '0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_prev_q <= 1'b0;
    end else begin
      dig_s1_q <= digital_in;
      dig_s2_q <= dig_s1_q;
      dig_prev_q <= dig_s2_q;
      inh_s1_q <= inhibit_in;
      inh_s2_q <= inh_s1_q;
      ack_s1_q <= ack_in;
      ack_s2_q <= ack_s1_q;
      ack_prev_q <= ack_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [NUM_ALARMS-1:0] soft_inhibit_q;
  logic soft_ack_q;
  logic [2:0] dig_kind_q [NUM_DIGITAL];
  logic [1:0] dig_latch_q [NUM_DIGITAL];
  logic dig_block_q [NUM_DIGITAL];
  logic [2:0] ana_kind_q [NUM_ANALOGUE];
  logic [1:0] ana_latch_q [NUM_ANALOGUE];
  logic ana_block_q [NUM_ANALOGUE];
  logic [3:0] ana_src_q [NUM_ANALOGUE];
  logic [VALUE_W-1:0] ana_ref_q [NUM_ANALOGUE];
  logic [VALUE_W-1:0] ana_thr_q [NUM_ANALOGUE];
  logic [VALUE_W-1:0] ana_hyst_q [NUM_ANALOGUE];
  logic [NUM_ANALOGUE-1:0] ana_rearm_q;
  logic [NUM_ALARMS-1:0] relay_sel_q [NUM_RELAYS];
  logic relay_inv_q [NUM_RELAYS];
  logic [NUM_ALARMS-1:0] active, unacked;

  logic wr_en;
  assign wr_en = psel & penable & pwrite;
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_inhibit_q <= '0;
      soft_ack_q <= 1'b0;
      ana_rearm_q <= '0;
      for (int i = 0; i < NUM_DIGITAL; i++) begin
        dig_kind_q[i] <= 3'h0;
        dig_latch_q[i] <= 2'h0;
        dig_block_q[i] <= 1'b0;
      end
      for (int i = 0; i < NUM_ANALOGUE; i++) begin
        ana_kind_q[i] <= 3'h0;
        ana_latch_q[i] <= 2'h0;
        ana_block_q[i] <= 1'b0;
        ana_src_q[i] <= 4'h0;
        ana_ref_q[i] <= '0;
        ana_thr_q[i] <= '0;
        ana_hyst_q[i] <= '0;
      end
      for (int i = 0; i < NUM_RELAYS; i++) begin
        relay_sel_q[i] <= '0;
        relay_inv_q[i] <= RST_RELAY_INV; // R11
      end
    end else begin
      soft_ack_q <= 1'b0;
      ana_rearm_q <= '0;
      if (wr_en) begin
        if (paddr == OFS_ACK) begin
          soft_ack_q <= pwdata[0]; // R24
        end else if (paddr == OFS_INHIBIT) begin
          soft_inhibit_q <= pwdata[NUM_ALARMS-1:0];
        end
        for (int i = 0; i < NUM_DIGITAL; i++) begin
          if (paddr == OFS_DIG_BASE + 12'(4 * i)) begin
            dig_kind_q[i] <= pwdata[FLD_TYPE_LSB+:3];
            dig_latch_q[i] <= pwdata[FLD_LATCH_LSB+:2];
            dig_block_q[i] <= pwdata[FLD_BLOCK];
          end
        end
        for (int i = 0; i < NUM_RELAYS; i++) begin
          if (paddr == OFS_RELAY_BASE + 12'(4 * i)) begin
            relay_sel_q[i] <= pwdata[NUM_ALARMS-1:0]; // R5
            relay_inv_q[i] <= pwdata[FLD_RELAY_INV]; // R11
          end
        end
        for (int i = 0; i < NUM_ANALOGUE; i++) begin
          if (paddr == OFS_ANA_BASE + 12'(16 * i) + OFS_ANA_CFG) begin
            ana_kind_q[i] <= pwdata[FLD_TYPE_LSB+:3];
            ana_latch_q[i] <= pwdata[FLD_LATCH_LSB+:2];
            ana_block_q[i] <= pwdata[FLD_BLOCK];
            ana_src_q[i] <= pwdata[FLD_SRC_LSB+:4];
          end else if (paddr == OFS_ANA_BASE + 12'(16 * i) + OFS_ANA_REF) begin
            ana_ref_q[i] <= pwdata[VALUE_W-1:0];
            ana_rearm_q[i] <= 1'b1; // R23
          end else if (paddr == OFS_ANA_BASE + 12'(16 * i) + OFS_ANA_THR) begin
            ana_thr_q[i] <= pwdata[VALUE_W-1:0];
            ana_rearm_q[i] <= 1'b1; // R23
          end else if (paddr == OFS_ANA_BASE + 12'(16 * i) + OFS_ANA_HYST) begin
            ana_hyst_q[i] <= pwdata[VALUE_W-1:0];
          end
        end
      end
    end
  end

  // Read data is registered during the setup cycle.
  logic [31:0] rd_d;
  logic rd_err;
  always_comb begin
    rd_d = RST_ZERO;
    rd_err = 1'b1;
    if (paddr == OFS_ACK || paddr == OFS_INHIBIT) begin
      rd_d[NUM_ALARMS-1:0] = (paddr == OFS_INHIBIT) ? soft_inhibit_q : '0;
      rd_err = 1'b0;
    end else if (paddr == OFS_STATUS) begin
      rd_d[NUM_ALARMS-1:0] = active; // R21
      rd_err = 1'b0;
    end else if (paddr == OFS_UNACK) begin
      rd_d[NUM_ALARMS-1:0] = unacked;
      rd_err = 1'b0;
    end
    for (int i = 0; i < NUM_DIGITAL; i++) begin
      if (paddr == OFS_DIG_BASE + 12'(4 * i)) begin
        rd_d[FLD_TYPE_LSB+:3] = dig_kind_q[i];
        rd_d[FLD_LATCH_LSB+:2] = dig_latch_q[i];
        rd_d[FLD_BLOCK] = dig_block_q[i];
        rd_err = 1'b0;
      end
    end
    for (int i = 0; i < NUM_RELAYS; i++) begin
      if (paddr == OFS_RELAY_BASE + 12'(4 * i)) begin
        rd_d[NUM_ALARMS-1:0] = relay_sel_q[i];
        rd_d[FLD_RELAY_INV] = relay_inv_q[i];
        rd_err = 1'b0;
      end
    end
    for (int i = 0; i < NUM_ANALOGUE; i++) begin
      if (paddr == OFS_ANA_BASE + 12'(16 * i) + OFS_ANA_CFG) begin
        rd_d[FLD_TYPE_LSB+:3] = ana_kind_q[i];
        rd_d[FLD_LATCH_LSB+:2] = ana_latch_q[i];
        rd_d[FLD_BLOCK] = ana_block_q[i];
        rd_d[FLD_SRC_LSB+:4] = ana_src_q[i];
        rd_err = 1'b0;
      end else if (paddr == OFS_ANA_BASE + 12'(16 * i) + OFS_ANA_REF) begin
        rd_d[VALUE_W-1:0] = ana_ref_q[i];
        rd_err = 1'b0;
      end else if (paddr == OFS_ANA_BASE + 12'(16 * i) + OFS_ANA_THR) begin
        rd_d[VALUE_W-1:0] = ana_thr_q[i];
        rd_err = 1'b0;
      end else if (paddr == OFS_ANA_BASE + 12'(16 * i) + OFS_ANA_HYST) begin
        rd_d[VALUE_W-1:0] = ana_hyst_q[i];
        rd_err = 1'b0;
      end
    end
  end

  logic [31:0] prdata_q;
  logic pslverr_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= RST_ZERO;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      prdata_q <= pwrite ? RST_ZERO : rd_d;
      pslverr_q <= rd_err;
    end
  end
  assign prdata = prdata_q;
  assign pslverr = pslverr_q & psel & penable;

  ////////////////////////////////////////////////////////////////////////////
  // Analogue condition detection with hysteresis.

  logic [NUM_ANALOGUE-1:0] ana_cond_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ana_cond_q <= '0;
    end else begin
      for (int i = 0; i < NUM_ANALOGUE; i++) begin
        logic signed [VALUE_W+1:0] pv, hi_lim, lo_lim, hy;
        logic over, under, over_safe, under_safe;
        pv = $signed({2'b00, analogue_in[VALUE_W*(ana_src_q[i] % NUM_INPUTS)+:VALUE_W]}); // R17
        hy = $signed({2'b00, ana_hyst_q[i]});
        if (ana_kind_q[i] == 3'(absolute_high_type) || ana_kind_q[i] == 3'(absolute_low_type)) begin
          hi_lim = $signed({2'b00, ana_thr_q[i]});
          lo_lim = $signed({2'b00, ana_thr_q[i]});
        end else begin
          hi_lim = $signed({2'b00, ana_ref_q[i]}) + $signed({2'b00, ana_thr_q[i]}); // R18
          lo_lim = $signed({2'b00, ana_ref_q[i]}) - $signed({2'b00, ana_thr_q[i]}); // R18
        end
        over = pv > hi_lim; // R19
        under = pv < lo_lim; // R19
        over_safe = pv < hi_lim - hy; // R20
        under_safe = pv > lo_lim + hy; // R20
        case (ana_kind_q[i])
          3'(absolute_high_type), 3'(deviation_high_type): begin
            ana_cond_q[i] <= ana_cond_q[i] ? !over_safe : over;
          end
          3'(absolute_low_type), 3'(deviation_low_type): begin
            ana_cond_q[i] <= ana_cond_q[i] ? !under_safe : under;
          end
          3'(deviation_band_type): begin
            ana_cond_q[i] <= ana_cond_q[i] ? !(over_safe && under_safe) : (over || under);
          end
          default: begin
            ana_cond_q[i] <= 1'b0; // R16
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm instances: analogue first, then digital.

  logic ack_all;
  assign ack_all = (ack_s2_q & ~ack_prev_q) | soft_ack_q; // R24

  for (genvar g = 0; g < NUM_ALARMS; g++) begin : g_alarm
    logic cond, evt;
    paev_mode_type mode;
    if (g < NUM_ANALOGUE) begin : g_ana
      assign cond = ana_cond_q[g]; // R15
      assign evt = 1'b0;
      assign mode = '{latch: paev_latch_type'(ana_latch_q[g]), block: ana_block_q[g]};
    end else begin : g_dig
      localparam int unsigned D = g - NUM_ANALOGUE;
      logic now, was;
      assign now = dig_s2_q[D];
      assign was = dig_prev_q[D];
      always_comb begin
        cond = 1'b0;
        evt = 1'b0;
        case (dig_kind_q[D])
          3'(rising_type): evt = now & ~was; // R1
          3'(falling_type): evt = ~now & was; // R2
          3'(either_edge_type): evt = now ^ was; // R3
          3'(high_level_type): cond = now; // R4
          3'(low_level_type): cond = ~now; // R4
          default: cond = 1'b0;
        endcase
      end
      assign mode = '{latch: paev_latch_type'(dig_latch_q[D]), block: dig_block_q[D]};
    end
    paev_latch_unit u_latch (
      .pclk(pclk),
      .presetn(presetn),
      .cond(cond),
      .edge_event(evt),
      .inhibit(inh_s2_q[g] | soft_inhibit_q[g]),
      .ack(ack_all),
      .rearm(g < NUM_ANALOGUE ? ana_rearm_q[g % NUM_ANALOGUE] : 1'b0),
      .mode(mode),
      .active(active[g]),
      .unacked(unacked[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicator and relays.

  logic [31:0] flash_cnt_q;
  logic flash_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cnt_q <= RST_ZERO;
      flash_q <= 1'b0;
    end else if (flash_cnt_q >= FLASH_HALF - 1) begin
      flash_cnt_q <= RST_ZERO;
      flash_q <= ~flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 32'h1;
    end
  end

  logic ind_q;
  logic [NUM_RELAYS-1:0] relay_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_q <= 1'b0;
    end else if (|unacked) begin
      ind_q <= flash_q; // R6
    end else begin
      ind_q <= |active; // R7
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_q <= '1;
    end else begin
      for (int r = 0; r < NUM_RELAYS; r++) begin
        relay_q[r] <= (|(relay_sel_q[r] & active)) ^ relay_inv_q[r]; // R5 R11
      end
    end
  end

  assign alarm_indicator = ind_q;
  assign relay_out = relay_q;

endmodule

// >>> verification/paev_plant.sv
`timescale 1ns/1ps
module paev_plant
  import paev_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] dig_cmd,
  input wire logic [63:0] ana_cmd,
  input wire logic ack_cmd,
  output logic [3:0] digital_in,
  output logic [63:0] analogue_in,
  output logic ack_in
);
  logic ack_seen_q;
  assign digital_in = dig_cmd;
  assign analogue_in = ana_cmd;
  // A held press still gives only one acknowledge pulse.
  assign ack_in = ack_cmd & ~ack_seen_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_seen_q <= 1'b0;
    end else begin
      ack_seen_q <= ack_cmd;
    end
  end
endmodule

// >>> verification/paev_top_sva.sv
`timescale 1ns/1ps
module paev_top_checker
  import paev_pkg::*;
#(
  parameter int unsigned FLASH_HALF = FLASH_HALF_CYC,
  parameter int unsigned NUM_INPUTS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_INPUTS*paev_pkg::VALUE_W-1:0] analogue_in,
  input wire logic [paev_pkg::NUM_DIGITAL-1:0] digital_in,
  input wire logic [paev_pkg::NUM_ALARMS-1:0] inhibit_in,
  input wire logic ack_in,
  input wire logic alarm_indicator,
  input wire logic [paev_pkg::NUM_RELAYS-1:0] relay_out
);
  logic [3:0] quiet_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Counts cycles with no cause that could move a relay.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_q <= 4'h0;
    end else if (psel || !$stable(digital_in) || !$stable(analogue_in)
                 || !$stable(inhibit_in) || !$stable(ack_in)) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hf) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  property p_relay_reset; $rose(presetn) |-> relay_out == 4'hf; endproperty
  property p_ind_reset; $rose(presetn) |-> !alarm_indicator && !pslverr; endproperty
  property p_pready; psel && penable |-> pready; endproperty
  property p_err_phase; pslverr |-> psel && penable; endproperty
  property p_err_zero; psel && penable && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  property p_status_ok; psel && penable && paddr == 12'h004 |-> !pslverr; endproperty
  property p_ana_ok;
    psel && penable && paddr >= 12'h040 && paddr < 12'h0c0 && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  property p_inhibit_quiet; inhibit_in == 12'hfff [*6] |-> !alarm_indicator; endproperty
  property p_relay_hold; quiet_q >= 4'h8 |-> $stable(relay_out); endproperty
  a_relay_reset: assert property (p_relay_reset) else $error("relay not idle after reset");
  a_ind_reset: assert property (p_ind_reset) else $error("indicator on after reset");
  a_pready: assert property (p_pready) else $error("pready low in access");
  a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
  a_err_zero: assert property (p_err_zero) else $error("unmapped read not zero");
  a_status_ok: assert property (p_status_ok) else $error("status read refused");
  a_ana_ok: assert property (p_ana_ok) else $error("analogue slot refused");
  a_inhibit_quiet: assert property (p_inhibit_quiet) else $error("inhibited alarm shown");
  a_relay_hold: assert property (p_relay_hold) else $error("relay moved without cause");
  c_relay: cover property ($fell(relay_out[0]));
  c_ind: cover property ($rose(alarm_indicator));
  c_err: cover property (pslverr);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind paev_top paev_top_checker #(.FLASH_HALF(FLASH_HALF), .NUM_INPUTS(NUM_INPUTS)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .analogue_in(analogue_in), .digital_in(digital_in), .inhibit_in(inhibit_in),
  .ack_in(ack_in), .alarm_indicator(alarm_indicator), .relay_out(relay_out)
);

// >>> verification/test_paev_top.sv
`timescale 1ns/1ps
module test_paev_top;
  import paev_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] dig_cmd = 4'h0;
  logic [63:0] ana_cmd = {4{16'h4000}};
  logic ack_cmd = 1'b0;
  logic [11:0] inhibit_in = 12'h000;
  logic [3:0] digital_in;
  logic [63:0] analogue_in;
  logic ack_in;
  logic alarm_indicator;
  logic [3:0] relay_out;
  logic [31:0] rd;
  logic err;
  logic seen;
  int num_errors = 0;
  int n_checks = 0;
  always #5 pclk = ~pclk;
  paev_top #(.FLASH_HALF(4), .NUM_INPUTS(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analogue_in(analogue_in), .digital_in(digital_in), .inhibit_in(inhibit_in),
    .ack_in(ack_in), .alarm_indicator(alarm_indicator), .relay_out(relay_out)
  );
  paev_plant u_plant (
    .pclk(pclk), .presetn(presetn), .dig_cmd(dig_cmd), .ana_cmd(ana_cmd),
    .ack_cmd(ack_cmd), .digital_in(digital_in), .analogue_in(analogue_in), .ack_in(ack_in)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      num_errors++;
      final_report();
    end
  endtask
  // Drives digital input 0 and notes whether relay 1 went into alarm meanwhile.
  task automatic dig(input logic v);
    dig_cmd[0] <= v;
    seen = 1'b0;
    repeat (8) begin
      @(posedge pclk);
      seen = seen | relay_out[1];
    end
  endtask
  task automatic press();
    ack_cmd <= 1'b1;
    @(posedge pclk);
    ack_cmd <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  task automatic expect_dig(input logic e);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[8], e);
    chk(relay_out[1:0], e ? 2'b10 : 2'b01);
  endtask
  task automatic flash(input logic e);
    int t;
    logic p;
    t = 0;
    p = alarm_indicator;
    repeat (12) begin
      @(posedge pclk);
      if (alarm_indicator !== p) t++;
      p = alarm_indicator;
    end
    chk(t > 1, e);
    if (!e) chk(alarm_indicator, 1'b1);
  endtask
  function automatic int ana_on(int ty, int v, int hi, int lo, int p);
    int up;
    int dn;
    up = p ? v >= hi - 'h100 : v > hi;
    dn = p ? v <= lo + 'h100 : v < lo;
    case (ty)
      1, 3: return up;
      2, 4: return dn;
      5: return up || dn;
      default: return 0;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int k, d, a, s, ty, thr, hi, lo, v, p;
    logic [63:0] vec;
    void'($urandom(61538));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(relay_out, 4'hf);
    chk(alarm_indicator, 1'b0);
    apb(1'b0, 12'hffc, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    apb(1'b1, 12'h020, 32'h0001_0100);
    apb(1'b1, 12'h024, 32'h0000_0100);
    for (k = 3; k <= 4; k++) begin
      apb(1'b1, 12'h010, k);
      dig(k == 4);
      expect_dig(1'b0);
      dig(k == 3);
      expect_dig(1'b1);
      flash(1'b1);
      if (k == 3) begin
        press();
        expect_dig(1'b1);
        flash(1'b0);
      end
      dig(k == 4);
      expect_dig(1'b0);
      chk(alarm_indicator, 1'b0);
    end
    for (k = 0; k < 3; k++) begin
      apb(1'b1, 12'h010, (k == 1) ? 32'h23 : 32'h13);
      dig(1'b1);
      if (k < 2) press();
      dig(1'b0);
      expect_dig(k != 0);
      if (k != 0) flash(1'b1);
      press();
      expect_dig(1'b0);
    end
    for (k = 0; k < 3; k++) begin
      apb(1'b1, 12'h010, k);
      for (d = 0; d < 2; d++) begin
        dig(d == 0);
        dig(d == 1);
        chk(seen, (k == 0 && d == 1) || (k == 1 && d == 0) || k == 2);
      end
    end
    apb(1'b1, 12'h010, 32'h3);
    dig(1'b1);
    inhibit_in <= 12'hfff;
    dig(1'b1);
    expect_dig(1'b0);
    inhibit_in <= 12'h000;
    dig(1'b1);
    expect_dig(1'b1);
    dig(1'b0);
    apb(1'b1, 12'h010, 32'h33);
    dig(1'b1);
    expect_dig(1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[8], 1'b0);
    flash(1'b0);
    dig(1'b0);
    expect_dig(1'b0);
    for (a = 0; a < 8; a++) begin
      ty = a % 6;
      thr = 'h800 + $urandom % 'h800;
      hi = 'h4000 + thr;
      lo = 'h4000 - thr;
      apb(1'b1, 12'(12'h040 + a * 16), ty | ((a % 4) << 12));
      apb(1'b1, 12'(12'h044 + a * 16), 32'h4000);
      apb(1'b1, 12'(12'h048 + a * 16), ty == 1 ? hi : ty == 2 ? lo : thr);
      apb(1'b1, 12'(12'h04c + a * 16), 32'h100);
      p = 0;
      for (s = 0; s < 12; s++) begin
        case (s)
          0, 7: v = 'h4000;
          1: v = hi + 'h40;
          2: v = hi - 'h80;
          3: v = hi - 'h180;
          4: v = lo - 'h40;
          5: v = lo + 'h80;
          6: v = lo + 'h180;
          default: v = 'h2800 + $urandom % 'h3000;
        endcase
        vec = {4{16'h4000}};
        vec[(a % 4) * 16 +: 16] = 16'(v);
        ana_cmd <= vec;
        repeat (8) @(posedge pclk);
        p = ana_on(ty, v, hi, lo, p);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd[a], p);
      end
      ana_cmd <= {4{16'h4000}};
    end
    // Blocking: a setpoint write while the condition stands holds the alarm off.
    apb(1'b1, 12'h00c, 32'h1);
    apb(1'b1, 12'h048, 32'h3000);
    apb(1'b1, 12'h040, 32'h101);
    apb(1'b1, 12'h044, 32'h0);
    apb(1'b1, 12'h00c, 32'h0);
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[0], 1'b0);
    ana_cmd <= {4{16'h2000}};
    repeat (4) @(posedge pclk);
    ana_cmd <= {4{16'h4000}};
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[0], 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[0], 1'b1);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[0], 1'b0);
    flash(1'b0);
    final_report();
  end
endmodule
